// File: dv/host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Host side view of the ready and interrupt lines
// ****************************************************************
module host_model (
  input wire logic clk,
  input wire logic ready_out,
  input wire logic ready_oe_n,
  input wire logic irq_out,
  input wire logic irq_oe_n,
  output logic ready_seen,
  output logic irq_seen
);
  logic ready_last_r;
  logic irq_last_r;
  // Remember the last driven level of each line
  always_ff @(posedge clk) begin
    if (!ready_oe_n) ready_last_r <= ready_out;
    if (!irq_oe_n) irq_last_r <= irq_out;
  end
  // A released line has no keeper, so show the opposite of the last level
  assign ready_seen = ready_oe_n ? ~ready_last_r : ready_out;
  assign irq_seen = irq_oe_n ? ~irq_last_r : irq_out;
endmodule
`default_nettype wire

// File: dv/host_port_pin_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module host_port_pin_control_tb import host_port_pin_pkg::*; ();
  logic clk, reset_n, clk_en, port_enable_strap, float_n, port_ready_in;
  logic irq_req_in, second_timer_output, irq_pin_sel_timer;
  logic host_ready_out, host_ready_oe_n, host_irq_out, host_irq_oe_n;
  logic port_enabled, strap_pulldown_en, ready_seen, irq_seen, en;
  int fails, check_count, seed;
  host_port_pin_control host_port_pin_control_i (.clk(clk), .reset_n(reset_n),
    .clk_en(clk_en), .port_enable_strap(port_enable_strap), .float_n(float_n),
    .port_ready_in(port_ready_in), .irq_req_in(irq_req_in),
    .second_timer_output(second_timer_output), .irq_pin_sel_timer(irq_pin_sel_timer),
    .host_ready_out(host_ready_out), .host_ready_oe_n(host_ready_oe_n),
    .host_irq_out(host_irq_out), .host_irq_oe_n(host_irq_oe_n),
    .port_enabled(port_enabled), .strap_pulldown_en(strap_pulldown_en));
  host_model host_model_i (.clk(clk), .ready_out(host_ready_out),
    .ready_oe_n(host_ready_oe_n), .irq_out(host_irq_out), .irq_oe_n(host_irq_oe_n),
    .ready_seen(ready_seen), .irq_seen(irq_seen));
  // ****************************************************************
  // Clock, checking and closing
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input logic seen, input logic exp, input string what);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Interrupt pin level expected one edge after the inputs
  function automatic logic exp_irq(input logic e, input logic r, input logic s, input logic t);
    if (e) return r ? IRQ_ACTIVE_LEVEL : IRQ_IDLE_LEVEL;
    return s ? t : IRQ_IDLE_LEVEL;
  endfunction
  // ****************************************************************
  // Stimulus tasks
  // ****************************************************************
  task automatic do_reset(input logic strap);
    reset_n = 1'b0;
    port_enable_strap = strap;
    repeat (12) @(negedge clk);
    check(host_irq_out, 1'b1, "irq level in reset");
    check(host_irq_oe_n, OE_DRIVE, "irq driven in reset");
    check(strap_pulldown_en, 1'b1, "strap pull");
    reset_n = 1'b1;
    repeat (2) @(negedge clk);
    check(port_enabled, 1'b0, "enable too early");
    @(negedge clk);
    check(port_enabled, strap, "captured enable");
    en = strap;
  endtask
  task automatic traffic(input int n);
    logic [31:0] r;
    logic exp_rdy;
    logic exp_int;
    exp_rdy = 1'b0;
    exp_int = 1'b1;
    for (int i = 0; i < n; i++) begin
      r = $random(seed);
      {port_ready_in, irq_req_in, second_timer_output, irq_pin_sel_timer} = r[3:0];
      // Strap wiggles after capture must be ignored
      port_enable_strap = r[4];
      // Enable dropped about one edge in four; first edge always runs
      clk_en = (i == 0) || (r[6:5] != 2'h0);
      @(negedge clk);
      // A frozen edge leaves every pin where it was
      if (clk_en) begin
        exp_rdy = en & port_ready_in;
        exp_int = exp_irq(en, irq_req_in, irq_pin_sel_timer, second_timer_output);
      end
      check(ready_seen, exp_rdy, "ready level");
      check(irq_seen, exp_int, "irq level");
      check(strap_pulldown_en, 1'b1, "strap pull");
      check(port_enabled, en, "enable held");
    end
    clk_en = 1'b1;
  endtask
  task automatic float_test();
    float_n = 1'b0;
    repeat (2) @(negedge clk);
    check(host_ready_oe_n, OE_DRIVE, "float too early");
    @(negedge clk);
    check(host_ready_oe_n, OE_FLOAT, "ready float");
    check(host_irq_oe_n, OE_FLOAT, "irq float");
    // Released lines show the inverse of the last driven level
    check(ready_seen, ~(en & port_ready_in), "host sees released ready");
    check(irq_seen, ~exp_irq(en, irq_req_in, 1'b1, second_timer_output),
      "host sees released irq");
    float_n = 1'b1;
    repeat (3) @(negedge clk);
    check(host_ready_oe_n, OE_DRIVE, "ready driven again");
    check(host_irq_oe_n, OE_DRIVE, "irq driven again");
  endtask
  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    seed = 32'h3522;
    fails = 0;
    check_count = 0;
    clk_en = 1'b1;
    float_n = 1'b1;
    {port_ready_in, irq_req_in, second_timer_output, irq_pin_sel_timer} = 4'h0;
    for (int k = 0; k < 4; k++) begin
      do_reset(k[0] ^ 1'b1);
      traffic(40);
      irq_pin_sel_timer = 1'b1;
      float_test();
    end
    stop_test();
  end
  initial begin
    #50000;
    fails++;
    stop_test();
  end
endmodule
`default_nettype wire

// File: logic/host_port_pin_control.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [R1] Ready pin tells host next transfer acceptable
// [R2] Ready pin floats while float input low
// [R3] Interrupt pin signals host; high in reset
// [R4] Disabled port may route second timer out
// [R5] Interrupt pin floats while float input low
// [R6] Board holds strap high through reset
// [R7] Strap sampled as reset releases, decides enable
// [R8] Weak strap pull always kept active
// [R9] Low or open strap disables until reset
module host_port_pin_control
  import host_port_pin_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic port_enable_strap,
  input wire logic float_n,
  input wire logic port_ready_in,
  input wire logic irq_req_in,
  input wire logic second_timer_output,
  input wire logic irq_pin_sel_timer,
  output logic host_ready_out,
  output logic host_ready_oe_n,
  output logic host_irq_out,
  output logic host_irq_oe_n,
  output logic port_enabled,
  output logic strap_pulldown_en
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic strap_s1_r;
  logic strap_s2_r;
  logic float_s1_r;
  logic float_s2_r;
  logic strap_s1_nxt;
  logic strap_s2_nxt;
  logic float_s1_nxt;
  logic float_s2_nxt;

  // Both pins come from the board, so two flops before any use
  always_comb begin
    strap_s1_nxt = port_enable_strap;
    strap_s2_nxt = strap_s1_r;
    float_s1_nxt = float_n;
    float_s2_nxt = float_s1_r;
  end

  // Float syncs reset to driving so the reset level is seen
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_s1_r <= STRAP_DISABLED_LEVEL;
      strap_s2_r <= STRAP_DISABLED_LEVEL;
      float_s1_r <= 1'b1;
      float_s2_r <= 1'b1;
    end else if (clk_en) begin
      strap_s1_r <= strap_s1_nxt;
      strap_s2_r <= strap_s2_nxt;
      float_s1_r <= float_s1_nxt;
      float_s2_r <= float_s2_nxt;
    end
  end

  // ****************************************************************
  // Strap capture and enable state
  // ****************************************************************
  port_state_t state_r;
  port_state_t state_nxt;
  logic [1:0] settle_r;
  logic [1:0] settle_nxt;

  // Wait for the sync chain to fill, then read the strap once
  always_comb begin
    state_nxt = state_r;
    settle_nxt = settle_r;
    unique case (state_r)
      ST_SETTLE: begin
        if (settle_r != SETTLE_ZERO) begin
          settle_nxt = settle_r - SETTLE_ONE;
        // [R7] strap decides enable
        end else if (strap_s2_r) begin
          state_nxt = ST_ENABLED;
        end else begin
          // [R9] low strap disables
          state_nxt = ST_DISABLED;
        end
      end
      // [R9] strap ignored afterwards
      ST_ENABLED: state_nxt = ST_ENABLED;
      ST_DISABLED: state_nxt = ST_DISABLED;
    endcase
  end

  // Only a new reset leaves the enabled or disabled states
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_SETTLE;
      settle_r <= SETTLE_CYCLES;
    end else if (clk_en) begin
      state_r <= state_nxt;
      settle_r <= settle_nxt;
    end
  end

  // ****************************************************************
  // Output pins
  // ****************************************************************
  logic ready_r;
  logic ready_oe_n_r;
  logic irq_r;
  logic irq_oe_n_r;
  logic enabled_r;
  logic pull_r;
  logic ready_nxt;
  logic ready_oe_n_nxt;
  logic irq_nxt;
  logic irq_oe_n_nxt;
  logic enabled_nxt;
  logic pull_nxt;

  // Every pin is registered; float costs three cycles of latency
  always_comb begin
    enabled_nxt = (state_nxt == ST_ENABLED);
    // [R8] pull always on
    pull_nxt = 1'b1;
    // [R1] ready only from a live port
    ready_nxt = enabled_nxt & port_ready_in;
    // [R2] ready floats
    ready_oe_n_nxt = float_s2_r ? OE_DRIVE : OE_FLOAT;
    if (state_nxt == ST_ENABLED) begin
      // [R3] request drives the pin low
      irq_nxt = irq_req_in ? IRQ_ACTIVE_LEVEL : IRQ_IDLE_LEVEL;
    end else if (state_nxt == ST_DISABLED && irq_pin_sel_timer) begin
      // [R4] timer takes the pin
      irq_nxt = second_timer_output;
    end else begin
      irq_nxt = IRQ_IDLE_LEVEL;
    end
    // [R5] interrupt floats in any function
    irq_oe_n_nxt = float_s2_r ? OE_DRIVE : OE_FLOAT;
  end

  // [R3] driven high during reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ready_r <= READY_RESET_LEVEL;
      ready_oe_n_r <= OE_DRIVE;
      irq_r <= IRQ_IDLE_LEVEL;
      irq_oe_n_r <= OE_DRIVE;
      enabled_r <= 1'b0;
      pull_r <= 1'b1;
    end else if (clk_en) begin
      ready_r <= ready_nxt;
      ready_oe_n_r <= ready_oe_n_nxt;
      irq_r <= irq_nxt;
      irq_oe_n_r <= irq_oe_n_nxt;
      enabled_r <= enabled_nxt;
      pull_r <= pull_nxt;
    end
  end

  assign host_ready_out = ready_r;
  assign host_ready_oe_n = ready_oe_n_r;
  assign host_irq_out = irq_r;
  assign host_irq_oe_n = irq_oe_n_r;
  assign port_enabled = enabled_r;
  assign strap_pulldown_en = pull_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_READY_FOLLOWS: assert property ( // [R1]
    clk_en && state_nxt == ST_ENABLED |=> host_ready_out == $past(port_ready_in))
    else $error("ready pin does not follow port ready");

  AST_READY_FLOAT: assert property ( // [R2]
    clk_en && !float_s2_r |=> host_ready_oe_n == OE_FLOAT)
    else $error("ready pin not floated");

  AST_IRQ_IDLE_SETTLE: assert property ( // [R3]
    state_r == ST_SETTLE |-> host_irq_out == IRQ_IDLE_LEVEL)
    else $error("interrupt pin not high before enable decided");

  AST_IRQ_REQ: assert property ( // [R3]
    clk_en && state_r == ST_ENABLED && irq_req_in |=> host_irq_out == IRQ_ACTIVE_LEVEL)
    else $error("interrupt request not shown on pin");

  AST_IRQ_TIMER: assert property ( // [R4]
    clk_en && state_r == ST_DISABLED && irq_pin_sel_timer
      |=> host_irq_out == $past(second_timer_output))
    else $error("timer output not routed to interrupt pin");

  AST_IRQ_FLOAT: assert property ( // [R5]
    clk_en && !float_s2_r |=> host_irq_oe_n == OE_FLOAT)
    else $error("interrupt pin not floated");

  // Checks the enable pin itself, not the next-state expression
  AST_CAPTURE: assert property ( // [R7]
    clk_en && state_r == ST_SETTLE && settle_r == SETTLE_ZERO
      |=> port_enabled == $past(strap_s2_r))
    else $error("strap captured wrongly");

  AST_PULL_ON: assert property ( // [R8]
    strap_pulldown_en)
    else $error("strap pull released");

  AST_DISABLED_STICKS: assert property ( // [R9]
    state_r == ST_DISABLED |=> state_r == ST_DISABLED && !port_enabled)
    else $error("disabled port woke without reset");

  AST_SETTLE_BOUND: assert property ( // [R7]
    $rose(reset_n) ##0 clk_en [*3] |=> state_r != ST_SETTLE)
    else $error("strap not captured in time");

  COV_ENABLED: cover property (state_r == ST_ENABLED && host_irq_out == IRQ_ACTIVE_LEVEL);
  COV_TIMER: cover property (state_r == ST_DISABLED && irq_pin_sel_timer && !host_irq_out);
  COV_FLOAT: cover property (host_ready_oe_n == OE_FLOAT && host_irq_oe_n == OE_FLOAT);
  COV_READY: cover property (host_ready_out ##1 !host_ready_out);

endmodule
`default_nettype wire

// File: logic/host_port_pin_pkg.sv
package host_port_pin_pkg;

  // ****************************************************************
  // Synchroniser and strap capture timing
  // ****************************************************************
  localparam int SYNC_STAGES = 2;
  // Enabled edges after reset release before the strap is read
  localparam logic [1:0] SETTLE_CYCLES = 2'h2;
  localparam logic [1:0] SETTLE_ZERO = 2'h0;
  localparam logic [1:0] SETTLE_ONE = 2'h1;

  // ****************************************************************
  // Pin levels
  // ****************************************************************
  // Interrupt pin is active low, so high means no request
  localparam logic IRQ_IDLE_LEVEL = 1'b1;
  localparam logic IRQ_ACTIVE_LEVEL = 1'b0;
  // Output enables are low while the pin is driven
  localparam logic OE_DRIVE = 1'b0;
  localparam logic OE_FLOAT = 1'b1;
  // Level an open strap settles to through the weak pull
  localparam logic STRAP_DISABLED_LEVEL = 1'b0;
  localparam logic READY_RESET_LEVEL = 1'b0;

  // ****************************************************************
  // Port state
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_SETTLE,
    ST_ENABLED,
    ST_DISABLED
  } port_state_t;

endpackage
